// *** hw/slr_pkg.sv ***
// shared types and constants of the serial link receive state machine
// assumes the physical layer hands over primitives already decoded to a code
package slr_pkg;

	localparam int SLR_DW = 32;
	localparam int SLR_BUF_DEPTH = 2;
	localparam logic [31:0] SLR_CRC_POLY = 32'h0000_0007;
	localparam logic [31:0] SLR_CRC_INIT = 32'hFFFF_FFFF;
	// crc over data plus its own crc word leaves this remainder
	localparam logic [31:0] SLR_CRC_RESIDUE = 32'h0000_0000;

	typedef enum logic [3:0] {
		SLR_PRIM_SYNC = 4'h0,
		SLR_PRIM_X_RDY = 4'h1,
		SLR_PRIM_R_RDY = 4'h2,
		SLR_PRIM_SOF = 4'h3,
		SLR_PRIM_EOF = 4'h4,
		SLR_PRIM_HOLD = 4'h5,
		SLR_PRIM_HOLDA = 4'h6,
		SLR_PRIM_WTRM = 4'h7,
		SLR_PRIM_R_IP = 4'h8,
		SLR_PRIM_R_OK = 4'h9,
		SLR_PRIM_R_ERR = 4'hA,
		SLR_PRIM_DMAT = 4'hB,
		SLR_PRIM_ALIGN = 4'hC,
		SLR_PRIM_OTHER = 4'hF
	} slr_prim_t;

	typedef enum logic [3:0] {
		SLR_ST_IDLE = 4'h0,
		SLR_ST_NO_COMM = 4'h1,
		SLR_ST_CHECK_READY = 4'h2,
		SLR_ST_WAIT_BUFFER = 4'h3,
		SLR_ST_DATA = 4'h4,
		SLR_ST_THROTTLE = 4'h5,
		SLR_ST_ACK_PAUSE = 4'h6,
		SLR_ST_FRAME_END = 4'h7,
		SLR_ST_CRC_OK = 4'h8,
		SLR_ST_GOOD_END = 4'h9,
		SLR_ST_FAIL_END = 4'hA
	} slr_state_t;

endpackage : slr_pkg

// *** hw/slr_crc.sv ***
// running frame crc, one dword per enabled cycle, msb first, no final inversion
// assumes clear and enable are never asserted together by the caller
`timescale 1ns/1ps
module slr_crc
	import slr_pkg::*;
#(
	parameter logic [31:0] POLY = SLR_CRC_POLY,
	parameter logic [31:0] INIT = SLR_CRC_INIT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic en,
	input wire logic [31:0] din,
	output logic [31:0] crc_q
);

	logic [31:0] crc_d;

	always_comb begin
		logic [31:0] c;
		c = crc_q;
		for (int i = 31; i >= 0; i--) begin
			if (c[31] ^ din[i]) begin
				c = {c[30:0], 1'b0} ^ POLY;
			end else begin
				c = {c[30:0], 1'b0};
			end
		end
		if (clr) begin
			crc_d = INIT;
		end else if (en) begin
			crc_d = c;
		end else begin
			crc_d = crc_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			crc_q <= INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

endmodule : slr_crc

// *** hw/slr_buf.sv ***
// small dword buffer between link and transport, valid/ready on both sides
// assumes the writer holds nothing when in_ready is low; the word is then its to keep
`timescale 1ns/1ps
module slr_buf
	import slr_pkg::*;
#(
	parameter int W = SLR_DW,
	parameter int DEPTH = SLR_BUF_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage needs no reset, only the pointers and the count do
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

endmodule : slr_buf

// *** hw/slr_rx_link.sv ***
// receive half of the serial link layer: handshake, frame data, flow control, end of frame
// assumes decoded primitives/dwords from the physical layer, one per cycle when rx_valid
//
// Functional notes
// - physical layer not ready in any receive state: notify, fail, enter no-comm error.
// - check_ready sends R_RDY continuously, stays on X_RDY, waits for SOF.
// - SOF in check_ready moves to data state, frame reception starts.
// - other dword in check_ready: notify transport, back to idle.
// - X_RDY while buffer cannot take a frame: wait_buffer, send SYNC.
// - wait_buffer: X_RDY and buffer ready to check_ready, else stay.
// - other dword in wait_buffer: notify transport, back to idle.
// - data state decodes each dword, passes it on, adds it to frame CRC.
// - data state sends R_IP, or DMAT when termination is requested.
// - data state holds on data or HOLDA with space, or other non-control dwords.
// - data state goes to throttle when transport reports too little space.
// - HOLD in data state moves to ack_pause.
// - EOF in data state moves to frame_end for CRC check.
// - WTRM in data state moves to fail_end, frame failed.
// - SYNC in data state reports abort, returns to idle.
// - pending control frame request drops the link to idle sending SYNC.
// - throttle sends HOLD continuously yet still accepts arriving dwords.
// - throttle returns to data on space and a dword other than HOLD/EOF.
// - HOLD with space in throttle moves to ack_pause.
// - EOF in throttle moves to frame_end; a late word into a full buffer sets overflow and fails the CRC check.
// - throttle holds while space short, phy ready, no EOF or SYNC.
// - SYNC in throttle reports illegal transition, returns to idle.
// - ack_pause sends HOLDA, or DMAT when termination is requested.
// - frame_end checks accumulated CRC while sending R_IP.
// - bad CRC or transport-declared invalid frame enters fail_end sending R_ERR.
`timescale 1ns/1ps
module slr_rx_link
	import slr_pkg::*;
#(
	parameter int DW = SLR_DW,
	parameter int BUF_DEPTH = SLR_BUF_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic phy_up_flag,
	input wire logic rx_valid,
	input wire logic rx_is_prim,
	input wire slr_prim_t rx_prim,
	input wire logic [DW-1:0] rx_data,
	output slr_prim_t tx_prim,
	input wire logic tl_frame_ready,
	input wire logic tl_space,
	input wire logic tl_term_req,
	input wire logic tl_good,
	input wire logic tl_bad,
	input wire logic ctl_frame_req,
	output logic out_valid,
	input wire logic out_ready,
	output logic [DW-1:0] out_data,
	output logic ev_no_comm,
	output logic ev_abort,
	output logic ev_illegal,
	output logic ev_crc_ok,
	output logic ev_crc_bad,
	output logic ev_frame_fail,
	output logic ev_frame_good,
	output slr_state_t rx_state
);

	slr_state_t st_q, st_d;
	slr_prim_t tx_q, tx_d;
	logic [DW-1:0] pend_q, pend_d;
	logic pend_vld_q, pend_vld_d;
	logic ovf_q, ovf_d;
	logic no_comm_q, no_comm_d;
	logic abort_q, abort_d;
	logic illegal_q, illegal_d;
	logic crc_ok_q, crc_ok_d;
	logic crc_bad_q, crc_bad_d;
	logic fail_q, fail_d;
	logic good_q, good_d;

	logic is_data, is_sync, is_xrdy, is_sof, is_eof, is_hold, is_holda, is_wtrm;
	logic space;
	logic crc_clr, crc_en;
	logic [31:0] crc_q;
	logic buf_in_valid, buf_in_ready;

	assign is_data = rx_valid && !rx_is_prim;
	assign is_sync = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_SYNC);
	assign is_xrdy = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_X_RDY);
	assign is_sof = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_SOF);
	assign is_eof = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_EOF);
	assign is_hold = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_HOLD);
	assign is_holda = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_HOLDA);
	assign is_wtrm = rx_valid && rx_is_prim && (rx_prim == SLR_PRIM_WTRM);

	// a full buffer counts as no space, so a stalled transport throttles the far end
	assign space = tl_space && buf_in_ready;

	// the last dword before EOF is the crc: hold each dword back one slot
	assign buf_in_valid = is_data && pend_vld_q && (st_q == SLR_ST_DATA
		|| st_q == SLR_ST_THROTTLE || st_q == SLR_ST_ACK_PAUSE);
	assign crc_clr = (st_q == SLR_ST_CHECK_READY) && is_sof;
	assign crc_en = buf_in_valid || (is_data && (st_q == SLR_ST_DATA
		|| st_q == SLR_ST_THROTTLE || st_q == SLR_ST_ACK_PAUSE));

	slr_crc u_crc (
		.core_clk(core_clk),
		.rst(rst),
		.clr(crc_clr),
		.en(crc_en),
		.din(rx_data),
		.crc_q(crc_q)
	);

	slr_buf #(
		.W(DW),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(pend_q),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// state transitions and event pulses
	always_comb begin
		st_d = st_q;
		no_comm_d = 1'b0;
		abort_d = 1'b0;
		illegal_d = 1'b0;
		crc_ok_d = 1'b0;
		crc_bad_d = 1'b0;
		fail_d = 1'b0;
		good_d = 1'b0;
		if (!phy_up_flag) begin
			if (st_q != SLR_ST_NO_COMM) begin
				no_comm_d = 1'b1;
				fail_d = (st_q != SLR_ST_IDLE);
			end
			st_d = SLR_ST_NO_COMM;
		end else if (ctl_frame_req && st_q != SLR_ST_IDLE && st_q != SLR_ST_NO_COMM) begin
			abort_d = 1'b1;
			st_d = SLR_ST_IDLE;
		end else begin
			case (st_q)
				SLR_ST_NO_COMM: begin
					st_d = SLR_ST_IDLE;
				end
				SLR_ST_IDLE: begin
					if (is_xrdy) begin
						st_d = tl_frame_ready ? SLR_ST_CHECK_READY : SLR_ST_WAIT_BUFFER;
					end
				end
				SLR_ST_WAIT_BUFFER: begin
					if (is_xrdy && tl_frame_ready) begin
						st_d = SLR_ST_CHECK_READY;
					end else if (rx_valid && !is_xrdy) begin
						abort_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end
				end
				SLR_ST_CHECK_READY: begin
					if (is_sof) begin
						st_d = SLR_ST_DATA;
					end else if (rx_valid && !is_xrdy) begin
						abort_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end
				end
				SLR_ST_DATA: begin
					if (is_sync) begin
						abort_d = 1'b1;
						fail_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end else if (is_eof) begin
						st_d = SLR_ST_FRAME_END;
					end else if (is_wtrm) begin
						fail_d = 1'b1;
						st_d = SLR_ST_FAIL_END;
					end else if (is_hold) begin
						st_d = SLR_ST_ACK_PAUSE;
					end else if (!space) begin
						st_d = SLR_ST_THROTTLE;
					end else begin
						st_d = SLR_ST_DATA;
					end
				end
				SLR_ST_THROTTLE: begin
					if (is_sync) begin
						illegal_d = 1'b1;
						fail_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end else if (is_eof) begin
						st_d = SLR_ST_FRAME_END;
					end else if (space && is_hold) begin
						st_d = SLR_ST_ACK_PAUSE;
					end else if (space && rx_valid && !is_hold) begin
						st_d = SLR_ST_DATA;
					end else begin
						st_d = SLR_ST_THROTTLE;
					end
				end
				SLR_ST_ACK_PAUSE: begin
					if (is_sync) begin
						illegal_d = 1'b1;
						fail_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end else if (is_eof) begin
						st_d = SLR_ST_FRAME_END;
					end else if (rx_valid && !is_hold) begin
						st_d = SLR_ST_DATA;
					end
				end
				SLR_ST_FRAME_END: begin
					// crc register already holds the last dword, so one cycle suffices
					if (crc_q == SLR_CRC_RESIDUE && !ovf_q) begin
						crc_ok_d = 1'b1;
						st_d = SLR_ST_CRC_OK;
					end else begin
						crc_bad_d = 1'b1;
						fail_d = 1'b1;
						st_d = SLR_ST_FAIL_END;
					end
				end
				SLR_ST_CRC_OK: begin
					if (is_sync) begin
						illegal_d = 1'b1;
						fail_d = 1'b1;
						st_d = SLR_ST_IDLE;
					end else if (tl_bad) begin
						fail_d = 1'b1;
						st_d = SLR_ST_FAIL_END;
					end else if (tl_good) begin
						good_d = 1'b1;
						st_d = SLR_ST_GOOD_END;
					end
				end
				SLR_ST_GOOD_END, SLR_ST_FAIL_END: begin
					if (is_sync) begin
						st_d = SLR_ST_IDLE;
					end
				end
				default: begin
					st_d = SLR_ST_IDLE;
				end
			endcase
		end
	end

	// transmitted primitive follows the state being entered
	always_comb begin
		case (st_d)
			SLR_ST_CHECK_READY: begin
				tx_d = SLR_PRIM_R_RDY;
			end
			SLR_ST_WAIT_BUFFER: begin
				tx_d = SLR_PRIM_SYNC;
			end
			SLR_ST_DATA: begin
				tx_d = tl_term_req ? SLR_PRIM_DMAT : SLR_PRIM_R_IP;
			end
			SLR_ST_THROTTLE: begin
				tx_d = SLR_PRIM_HOLD;
			end
			SLR_ST_ACK_PAUSE: begin
				tx_d = tl_term_req ? SLR_PRIM_DMAT : SLR_PRIM_HOLDA;
			end
			SLR_ST_FRAME_END, SLR_ST_CRC_OK: begin
				tx_d = SLR_PRIM_R_IP;
			end
			SLR_ST_GOOD_END: begin
				tx_d = SLR_PRIM_R_OK;
			end
			SLR_ST_FAIL_END: begin
				tx_d = SLR_PRIM_R_ERR;
			end
			default: begin
				tx_d = SLR_PRIM_SYNC;
			end
		endcase
	end

	// hold-back slot and overflow tracking
	always_comb begin
		pend_d = pend_q;
		pend_vld_d = pend_vld_q;
		ovf_d = ovf_q;
		if (crc_clr) begin
			pend_vld_d = 1'b0;
			ovf_d = 1'b0;
		end else if (crc_en) begin
			// throttle keeps taking words; a word lost to a full buffer spoils the frame
			pend_d = rx_data;
			pend_vld_d = 1'b1;
			if (buf_in_valid && !buf_in_ready) begin
				ovf_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= SLR_ST_IDLE;
			tx_q <= SLR_PRIM_SYNC;
			pend_q <= '0;
			pend_vld_q <= 1'b0;
			ovf_q <= 1'b0;
			no_comm_q <= 1'b0;
			abort_q <= 1'b0;
			illegal_q <= 1'b0;
			crc_ok_q <= 1'b0;
			crc_bad_q <= 1'b0;
			fail_q <= 1'b0;
			good_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tx_q <= tx_d;
			pend_q <= pend_d;
			pend_vld_q <= pend_vld_d;
			ovf_q <= ovf_d;
			no_comm_q <= no_comm_d;
			abort_q <= abort_d;
			illegal_q <= illegal_d;
			crc_ok_q <= crc_ok_d;
			crc_bad_q <= crc_bad_d;
			fail_q <= fail_d;
			good_q <= good_d;
		end
	end

	assign tx_prim = tx_q;
	assign rx_state = st_q;
	assign ev_no_comm = no_comm_q;
	assign ev_abort = abort_q;
	assign ev_illegal = illegal_q;
	assign ev_crc_ok = crc_ok_q;
	assign ev_crc_bad = crc_bad_q;
	assign ev_frame_fail = fail_q;
	assign ev_frame_good = good_q;

endmodule : slr_rx_link

// *** sim/slr_rx_link_monitor.sv ***
// concurrent checks on the receive link state machine ports
// assumes one clock domain, sync active-high reset
`timescale 1ns/1ps
module slr_rx_link_monitor
	import slr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic phy_up_flag,
	input wire logic rx_valid,
	input wire logic rx_is_prim,
	input wire slr_prim_t rx_prim,
	input wire logic ctl_frame_req,
	input wire slr_prim_t tx_prim,
	input wire slr_state_t rx_state,
	input wire logic ev_no_comm,
	input wire logic ev_abort,
	input wire logic ev_illegal
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// only primitives that no higher-priority event overrides
	wire pv = phy_up_flag & ~ctl_frame_req & rx_valid & rx_is_prim;
	property p_no_comm;
		!phy_up_flag && rx_state inside {SLR_ST_CHECK_READY, SLR_ST_DATA, SLR_ST_THROTTLE}
			|=> rx_state == SLR_ST_NO_COMM && ev_no_comm;
	endproperty
	a_no_comm: assert property (p_no_comm) else $error("phy loss not handled");
	property p_recover;
		rx_state == SLR_ST_NO_COMM && phy_up_flag |-> ##[1:2] rx_state == SLR_ST_IDLE;
	endproperty
	a_recover: assert property (p_recover) else $error("no return to idle");
	property p_rdy_tx;
		rx_state == SLR_ST_CHECK_READY |-> tx_prim == SLR_PRIM_R_RDY;
	endproperty
	a_rdy_tx: assert property (p_rdy_tx) else $error("ready reply missing");
	property p_sof;
		pv && rx_prim == SLR_PRIM_SOF && rx_state == SLR_ST_CHECK_READY |=> rx_state == SLR_ST_DATA;
	endproperty
	a_sof: assert property (p_sof) else $error("start of frame ignored");
	property p_wait_tx;
		rx_state == SLR_ST_WAIT_BUFFER |-> tx_prim == SLR_PRIM_SYNC;
	endproperty
	a_wait_tx: assert property (p_wait_tx) else $error("wait state not idling");
	property p_data_tx;
		rx_state == SLR_ST_DATA |-> tx_prim inside {SLR_PRIM_R_IP, SLR_PRIM_DMAT};
	endproperty
	a_data_tx: assert property (p_data_tx) else $error("bad reply in data");
	property p_hold_tx;
		rx_state == SLR_ST_THROTTLE |-> tx_prim == SLR_PRIM_HOLD;
	endproperty
	a_hold_tx: assert property (p_hold_tx) else $error("throttle not holding");
	property p_eof;
		pv && rx_prim == SLR_PRIM_EOF && rx_state inside {SLR_ST_DATA, SLR_ST_THROTTLE}
			|=> rx_state == SLR_ST_FRAME_END && tx_prim == SLR_PRIM_R_IP;
	endproperty
	a_eof: assert property (p_eof) else $error("end of frame missed");
	property p_abort;
		pv && rx_prim == SLR_PRIM_SYNC && rx_state == SLR_ST_DATA |=> rx_state == SLR_ST_IDLE && ev_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not reported");
	property p_illegal;
		pv && rx_prim == SLR_PRIM_SYNC && rx_state == SLR_ST_THROTTLE |=> ev_illegal;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal sync unreported");
	property p_ctl;
		ctl_frame_req && phy_up_flag && rx_state == SLR_ST_DATA
			|=> rx_state == SLR_ST_IDLE && tx_prim == SLR_PRIM_SYNC;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control request ignored");
	c_throttle: cover property (rx_state == SLR_ST_THROTTLE);
	c_good: cover property (rx_state == SLR_ST_GOOD_END);
	c_fail: cover property (rx_state == SLR_ST_FAIL_END);
endmodule : slr_rx_link_monitor

bind slr_rx_link slr_rx_link_monitor u_mon (.core_clk, .rst, .phy_up_flag, .rx_valid,
	.rx_is_prim, .rx_prim, .ctl_frame_req, .tx_prim, .rx_state, .ev_no_comm, .ev_abort,
	.ev_illegal);

// *** sim/slr_peer.sv ***
// far-side model: remote link handing decoded dwords and primitives over the phy
// assumes one caller, one dword per clock
`timescale 1ns/1ps
module slr_peer
	import slr_pkg::*;
(
	input wire logic core_clk,
	output logic rx_valid,
	output logic rx_is_prim,
	output slr_prim_t rx_prim,
	output logic [31:0] rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_is_prim = 1'b0;
		rx_prim = SLR_PRIM_OTHER;
		rx_data = 32'h0;
	end
	// unused lanes get fresh junk so a stale value never passes for a real one
	task automatic put(input logic ip, input slr_prim_t p, input logic [31:0] d);
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_is_prim <= ip;
		rx_prim <= ip ? p : slr_prim_t'(~rx_prim);
		rx_data <= ip ? ~rx_data : d;
	endtask : put
	task automatic idle();
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_is_prim <= ~rx_is_prim;
		rx_prim <= slr_prim_t'(~rx_prim);
		rx_data <= ~rx_data;
	endtask : idle
endmodule : slr_peer

// *** sim/tb.sv ***
// self-checking bench: state decisions as table rows, then frames and forced exits
// assumes slr_peer stands for the phy side
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
	import slr_pkg::*;
	typedef struct packed {logic thr; logic sp; slr_prim_t p; slr_state_t s;} slr_row_t;
	logic core_clk, rst, phy_up_flag, tl_frame_ready, tl_space, tl_term_req;
	logic tl_good, tl_bad, ctl_frame_req, out_ready, out_valid, rx_valid, rx_is_prim;
	logic ev_no_comm, ev_abort, ev_illegal, ev_crc_ok, ev_crc_bad, ev_frame_good, ev_frame_fail;
	logic [31:0] rx_data, out_data, c;
	slr_prim_t rx_prim, tx_prim;
	slr_state_t rx_state;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	slr_row_t rows [12] = '{
		'{0, 1, SLR_PRIM_HOLD, SLR_ST_ACK_PAUSE},
		'{0, 1, SLR_PRIM_EOF, SLR_ST_FRAME_END},
		'{0, 1, SLR_PRIM_WTRM, SLR_ST_FAIL_END},
		'{0, 1, SLR_PRIM_SYNC, SLR_ST_IDLE},
		'{0, 1, SLR_PRIM_HOLDA, SLR_ST_DATA},
		'{0, 1, SLR_PRIM_X_RDY, SLR_ST_DATA},
		'{0, 0, SLR_PRIM_ALIGN, SLR_ST_THROTTLE},
		'{1, 0, SLR_PRIM_ALIGN, SLR_ST_THROTTLE},
		'{1, 1, SLR_PRIM_ALIGN, SLR_ST_DATA},
		'{1, 1, SLR_PRIM_HOLD, SLR_ST_ACK_PAUSE},
		'{1, 0, SLR_PRIM_EOF, SLR_ST_FRAME_END},
		'{1, 0, SLR_PRIM_SYNC, SLR_ST_IDLE}
	};
	slr_rx_link DUT (.core_clk, .rst, .phy_up_flag, .rx_valid, .rx_is_prim, .rx_prim,
		.rx_data, .tx_prim, .tl_frame_ready, .tl_space, .tl_term_req, .tl_good, .tl_bad,
		.ctl_frame_req, .out_valid, .out_ready, .out_data, .ev_no_comm, .ev_abort,
		.ev_illegal, .ev_crc_ok, .ev_crc_bad, .ev_frame_fail, .ev_frame_good, .rx_state);
	slr_peer peer (.core_clk, .rx_valid, .rx_is_prim, .rx_prim, .rx_data);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			final_report();
		end
	end
	function automatic logic [31:0] crc_f(input logic [31:0] r, input logic [31:0] d);
		r = r ^ d;
		for (int i = 0; i < 32; i++) r = r[31] ? (r << 1) ^ SLR_CRC_POLY : r << 1;
		return r;
	endfunction : crc_f
	task automatic do_rst(input int n);
		@(posedge core_clk);
		rst <= 1'b1;
		phy_up_flag <= 1'b1;
		tl_frame_ready <= 1'b1;
		tl_space <= 1'b1;
		tl_term_req <= 1'b0;
		ctl_frame_req <= 1'b0;
		out_ready <= 1'b1;
		repeat (n) @(posedge core_clk);
		rst <= 1'b0;
	endtask : do_rst
	task automatic go(input slr_prim_t p, input slr_state_t s);
		peer.put(1'b1, p, 32'h0);
		peer.idle();
		#1 `CHK("rx_state", s, rx_state)
	endtask : go
	task automatic to_data();
		do_rst(1);
		go(SLR_PRIM_X_RDY, SLR_ST_CHECK_READY);
		go(SLR_PRIM_X_RDY, SLR_ST_CHECK_READY);
		go(SLR_PRIM_SOF, SLR_ST_DATA);
	endtask : to_data
	// receiver stalled: two words must wait in the buffer, the crc word never lands
	task automatic frame(input logic [31:0] x, input slr_state_t s);
		c = crc_f(crc_f(SLR_CRC_INIT, 32'hA5A50001), 32'h5A5A0002);
		to_data();
		@(posedge core_clk);
		out_ready <= 1'b0;
		peer.put(1'b0, SLR_PRIM_OTHER, 32'hA5A50001);
		peer.put(1'b0, SLR_PRIM_OTHER, 32'h5A5A0002);
		peer.put(1'b0, SLR_PRIM_OTHER, c ^ x);
		go(SLR_PRIM_EOF, SLR_ST_FRAME_END);
		for (int i = 0; i < 4 && !(ev_crc_ok | ev_crc_bad); i++) @(posedge core_clk) #1;
		`CHK("verdict", s, rx_state)
		`CHK("crc_ok", x == 0, ev_crc_ok)
		// verdict pulses last one cycle, so they are looked at here and not later
		`CHK("crc_bad", x != 0, ev_crc_bad)
		`CHK("fail ev", x != 0, ev_frame_fail)
		`CHK("full", 1'b1, out_valid)
		@(posedge core_clk);
		out_ready <= 1'b1;
		#1 `CHK("word0", 32'hA5A50001, out_data)
		@(posedge core_clk);
		#1 `CHK("word1", 32'h5A5A0002, out_data)
		@(posedge core_clk);
		#1 `CHK("empty", 1'b0, out_valid)
	endtask : frame
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		rst = 1'b1;
		phy_up_flag = 1'b1;
		tl_frame_ready = 1'b1;
		tl_space = 1'b1;
		tl_term_req = 1'b0;
		tl_good = 1'b0;
		tl_bad = 1'b0;
		ctl_frame_req = 1'b0;
		out_ready = 1'b1;
		do_rst(5);
		#1 `CHK("rst state", SLR_ST_IDLE, rx_state)
		`CHK("rst tx", SLR_PRIM_SYNC, tx_prim)
		`CHK("rst out", 1'b0, out_valid)
		foreach (rows[i]) begin
			to_data();
			if (rows[i].thr) begin
				@(posedge core_clk);
				tl_space <= 1'b0;
				go(SLR_PRIM_ALIGN, SLR_ST_THROTTLE);
			end
			@(posedge core_clk);
			tl_space <= rows[i].sp;
			go(rows[i].p, rows[i].s);
		end
		$display("test rows done");
		do_rst(1);
		@(posedge core_clk);
		tl_frame_ready <= 1'b0;
		go(SLR_PRIM_X_RDY, SLR_ST_WAIT_BUFFER);
		go(SLR_PRIM_X_RDY, SLR_ST_WAIT_BUFFER);
		@(posedge core_clk);
		tl_frame_ready <= 1'b1;
		go(SLR_PRIM_X_RDY, SLR_ST_CHECK_READY);
		go(SLR_PRIM_ALIGN, SLR_ST_IDLE);
		@(posedge core_clk);
		tl_frame_ready <= 1'b0;
		go(SLR_PRIM_X_RDY, SLR_ST_WAIT_BUFFER);
		go(SLR_PRIM_HOLD, SLR_ST_IDLE);
		$display("test wait buffer done");
		frame(32'h0, SLR_ST_CRC_OK);
		@(posedge core_clk);
		tl_good <= 1'b1;
		@(posedge core_clk);
		tl_good <= 1'b0;
		#1 `CHK("good end", SLR_ST_GOOD_END, rx_state)
		`CHK("good ev", 1'b1, ev_frame_good)
		frame(32'h1, SLR_ST_FAIL_END);
		// the crc verdict pulse has long gone while the error reply still stands
		`CHK("bad ev", 1'b0, ev_crc_bad)
		`CHK("bad tx", SLR_PRIM_R_ERR, tx_prim)
		frame(32'h0, SLR_ST_CRC_OK);
		@(posedge core_clk);
		tl_bad <= 1'b1;
		@(posedge core_clk);
		tl_bad <= 1'b0;
		#1 `CHK("tl bad", SLR_ST_FAIL_END, rx_state)
		`CHK("tl bad ev", 1'b1, ev_frame_fail)
		`CHK("tl bad tx", SLR_PRIM_R_ERR, tx_prim)
		$display("test frames done");
		to_data();
		@(posedge core_clk);
		tl_term_req <= 1'b1;
		go(SLR_PRIM_ALIGN, SLR_ST_DATA);
		`CHK("term tx", SLR_PRIM_DMAT, tx_prim)
		@(posedge core_clk);
		tl_term_req <= 1'b0;
		go(SLR_PRIM_HOLD, SLR_ST_ACK_PAUSE);
		`CHK("pause tx", SLR_PRIM_HOLDA, tx_prim)
		to_data();
		@(posedge core_clk);
		ctl_frame_req <= 1'b1;
		@(posedge core_clk);
		ctl_frame_req <= 1'b0;
		#1 `CHK("ctl tx", SLR_PRIM_SYNC, tx_prim)
		`CHK("ctl state", SLR_ST_IDLE, rx_state)
		`CHK("ctl ev", 1'b1, ev_abort)
		to_data();
		@(posedge core_clk);
		phy_up_flag <= 1'b0;
		@(posedge core_clk);
		#1 `CHK("phy down", SLR_ST_NO_COMM, rx_state)
		`CHK("phy ev", 1'b1, ev_no_comm)
		`CHK("phy fail", 1'b1, ev_frame_fail)
		@(posedge core_clk);
		phy_up_flag <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 `CHK("phy back", SLR_ST_IDLE, rx_state)
		$display("test forced exits done");
		final_report();
	end
endmodule : tb
